// >>> design/gpio_pkg.sv
// Contract
// - Each port bit's direction is set by software independently of its neighbours.
// - Direction bit one makes the pin an output, zero an input.
// - Eight-bit port input pins have a per-pin software pull-up enable.
// - Output direction forces the pin's pull-up off regardless of software selection.
// - Eight-bit port pins can be key-scan inputs or open-drain outputs.
// - Port b bits 1,2,4 feed interrupts/counter; bits 5,6,7 carry timer outputs.
// - Port c has five push-pull bits with pull-up and direction control.
// - Reset is active low with internal pull-up; the other party drives it low.
package gpio_pkg;
    localparam int unsigned AW = 6;
    localparam logic [AW-1:0] ADDR_A_DATA  = 6'h00;
    localparam logic [AW-1:0] ADDR_A_DIR   = 6'h04;
    localparam logic [AW-1:0] ADDR_A_PULL  = 6'h08;
    localparam logic [AW-1:0] ADDR_A_OD    = 6'h0c;
    localparam logic [AW-1:0] ADDR_A_KS    = 6'h10;
    localparam logic [AW-1:0] ADDR_B_DATA  = 6'h14;
    localparam logic [AW-1:0] ADDR_B_DIR   = 6'h18;
    localparam logic [AW-1:0] ADDR_B_PULL  = 6'h1c;
    localparam logic [AW-1:0] ADDR_B_OD    = 6'h20;
    localparam logic [AW-1:0] ADDR_B_KS    = 6'h24;
    localparam logic [AW-1:0] ADDR_B_ALT   = 6'h28;
    localparam logic [AW-1:0] ADDR_C_DATA  = 6'h2c;
    localparam logic [AW-1:0] ADDR_C_DIR   = 6'h30;
    localparam logic [AW-1:0] ADDR_C_PULL  = 6'h34;
    localparam logic [AW-1:0] ADDR_CTRL    = 6'h38;
    localparam logic [AW-1:0] ADDR_PIN_IN  = 6'h3c;
    // Alternate-function enable bits in port b alt register
    localparam int unsigned ALT_IRQ1 = 1;
    localparam int unsigned ALT_IRQ2 = 2;
    localparam int unsigned ALT_EC   = 4;
    localparam int unsigned ALT_T2   = 5;
    localparam int unsigned ALT_T1   = 6;
    localparam int unsigned ALT_T0   = 7;
    // Control register bits
    localparam int unsigned CTRL_STOP = 0;
    localparam int unsigned CTRL_REM  = 1;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] pull;
        logic [7:0] od;
        logic [7:0] ks;
    } port_cfg_t;

    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe;
        logic [7:0] pu;
    } pin_drive_t;
endpackage

// >>> design/gpio_ports.sv
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
module gpio_ports import gpio_pkg::*; #(
    parameter int unsigned C_BITS = 5
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  port_a_in,
    output pin_drive_t       port_a_drv,
    input  wire logic [7:0]  port_b_in,
    output pin_drive_t       port_b_drv,
    input  wire logic [C_BITS-1:0] port_c_in,
    output logic [C_BITS-1:0] port_c_o,
    output logic [C_BITS-1:0] port_c_oe,
    output logic [C_BITS-1:0] port_c_pu,
    input  wire logic        timer_out_zero,
    input  wire logic        timer_out_one,
    input  wire logic        timer_out_two,
    output logic             ext_irq_in_first,
    output logic             ext_irq_in_second,
    output logic             event_count_in,
    output logic             key_scan_hit,
    output logic             stop_mode,
    output logic             remote_drive_out
);
    if (C_BITS < 1 || C_BITS > 8) begin : g_bad_c_bits
        $error("C_BITS must be 1..8");
    end

    port_cfg_t       a_reg, b_reg;
    logic [7:0]      b_alt_reg;
    logic [C_BITS-1:0] c_data_reg, c_dir_reg, c_pull_reg;
    logic [1:0]      ctrl_reg;

    // Write channel: address and data latched independently, in any order
    logic            aw_have, w_have;
    logic [AW-1:0]   aw_addr;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    wire             wr_fire = aw_have && w_have && !s_axi_bvalid;
    wire             wr_lane = w_strb[0];
    wire [7:0]       wb = w_data[7:0];
    wire             stop_now = ctrl_reg[CTRL_STOP];
    // Ready flags are flops, so a slot is taken only while ready shows high
    wire             aw_take = s_axi_awvalid && s_axi_awready;
    wire             w_take = s_axi_wvalid && s_axi_wready;
    wire             aw_have_next = !wr_fire && (aw_have || aw_take);
    wire             w_have_next = !wr_fire && (w_have || w_take);
    wire             wr_bad = aw_addr > ADDR_CTRL || aw_addr[1:0] != 2'b00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            aw_have       <= aw_have_next;
            w_have        <= w_have_next;
            s_axi_awready <= !aw_have_next;
            s_axi_wready  <= !w_have_next;
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire do_wr = wr_fire && wr_lane;

    // Each register write touches only its own byte, bits independent
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_reg      <= '0;
            b_reg      <= '0;
            b_alt_reg  <= RST_BYTE;
            c_data_reg <= '0;
            c_dir_reg  <= '0;
            c_pull_reg <= '0;
            ctrl_reg   <= '0;
        end else if (do_wr) begin
            unique case (aw_addr)
                ADDR_A_DATA: a_reg.data <= wb;
                ADDR_A_DIR:  a_reg.dir  <= wb;
                ADDR_A_PULL: a_reg.pull <= wb;
                ADDR_A_OD:   a_reg.od   <= wb;
                ADDR_A_KS:   a_reg.ks   <= wb;
                ADDR_B_DATA: b_reg.data <= wb;
                ADDR_B_DIR:  b_reg.dir  <= wb;
                ADDR_B_PULL: b_reg.pull <= wb;
                ADDR_B_OD:   b_reg.od   <= wb;
                ADDR_B_KS:   b_reg.ks   <= wb;
                ADDR_B_ALT:  b_alt_reg  <= wb;
                ADDR_C_DATA: c_data_reg <= wb[C_BITS-1:0];
                ADDR_C_DIR:  c_dir_reg  <= wb[C_BITS-1:0];
                ADDR_C_PULL: c_pull_reg <= wb[C_BITS-1:0];
                ADDR_CTRL:   ctrl_reg   <= wb[1:0];
                default: ;
            endcase
        end
    end

    // Timer outputs override port b data where the alternate function is on
    logic [7:0] b_out;
    assign b_out = {b_alt_reg[ALT_T0] ? timer_out_zero : b_reg.data[7],
                    b_alt_reg[ALT_T1] ? timer_out_one  : b_reg.data[6],
                    b_alt_reg[ALT_T2] ? timer_out_two  : b_reg.data[5],
                    b_reg.data[4:0]};

    // Open-drain: drive only the low level, release for a one
    function automatic pin_drive_t drive8(input logic [7:0] d, input logic [7:0] dir,
                                          input logic [7:0] pull, input logic [7:0] od);
        pin_drive_t r;
        r.o  = d & ~od;
        r.oe = dir & ~(od & d);
        r.pu = pull & ~dir;
        return r;
    endfunction

    wire pin_drive_t a_next = drive8(a_reg.data, a_reg.dir, a_reg.pull, a_reg.od);
    wire pin_drive_t b_next = drive8(b_out, b_reg.dir, b_reg.pull, b_reg.od);

    // Key scan: any enabled input pin pulled low
    wire ks_next = |(a_reg.ks & ~a_reg.dir & ~port_a_in) | |(b_reg.ks & ~b_reg.dir & ~port_b_in);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (s_axi_araddr)
            ADDR_A_DATA: rd_mux[7:0] = a_reg.data;
            ADDR_A_DIR:  rd_mux[7:0] = a_reg.dir;
            ADDR_A_PULL: rd_mux[7:0] = a_reg.pull;
            ADDR_A_OD:   rd_mux[7:0] = a_reg.od;
            ADDR_A_KS:   rd_mux[7:0] = a_reg.ks;
            ADDR_B_DATA: rd_mux[7:0] = b_reg.data;
            ADDR_B_DIR:  rd_mux[7:0] = b_reg.dir;
            ADDR_B_PULL: rd_mux[7:0] = b_reg.pull;
            ADDR_B_OD:   rd_mux[7:0] = b_reg.od;
            ADDR_B_KS:   rd_mux[7:0] = b_reg.ks;
            ADDR_B_ALT:  rd_mux[7:0] = b_alt_reg;
            ADDR_C_DATA: rd_mux[C_BITS-1:0] = c_data_reg;
            ADDR_C_DIR:  rd_mux[C_BITS-1:0] = c_dir_reg;
            ADDR_C_PULL: rd_mux[C_BITS-1:0] = c_pull_reg;
            ADDR_CTRL:   rd_mux[1:0] = ctrl_reg;
            ADDR_PIN_IN: rd_mux[23:0] = {{(8-C_BITS){1'b0}}, port_c_in, port_b_in, port_a_in};
            default:     rd_mux = '0;
        endcase
    end
    wire rd_bad = s_axi_araddr > ADDR_PIN_IN || s_axi_araddr[1:0] != 2'b00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_bad ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Pin stage; in stop mode the port drives hold and the remote output is forced low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_a_drv        <= '0;
            port_b_drv        <= '0;
            port_c_o          <= '0;
            port_c_oe         <= '0;
            port_c_pu         <= '0;
            ext_irq_in_first  <= 1'b0;
            ext_irq_in_second <= 1'b0;
            event_count_in    <= 1'b0;
            key_scan_hit      <= 1'b0;
            stop_mode         <= 1'b0;
            remote_drive_out  <= 1'b0;
        end else begin
            stop_mode <= stop_now;
            if (!stop_now) begin
                port_a_drv <= a_next;
                port_b_drv <= b_next;
                port_c_o   <= c_data_reg;
                port_c_oe  <= c_dir_reg;
                port_c_pu  <= c_pull_reg & ~c_dir_reg;
            end
            ext_irq_in_first  <= b_alt_reg[ALT_IRQ1] & port_b_in[1];
            ext_irq_in_second <= b_alt_reg[ALT_IRQ2] & port_b_in[2];
            event_count_in    <= b_alt_reg[ALT_EC] & port_b_in[4];
            key_scan_hit      <= ks_next;
            remote_drive_out  <= ctrl_reg[CTRL_REM] & ~stop_now;
        end
    end

    property p_pullup_off;
        @(posedge aclk) disable iff (!aresetn)
        1'b1 |-> ((port_a_drv.pu & port_a_drv.oe) == 8'h00) && ((port_c_pu & port_c_oe) == '0)
                 && ((port_b_drv.pu & port_b_drv.oe) == 8'h00);
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("Pull-up on while driving");

    property p_remote_stop;
        @(posedge aclk) disable iff (!aresetn)
        stop_now |=> !remote_drive_out;
    endproperty
    a_remote_stop: assert property (p_remote_stop) else $error("Remote output high in stop");

    property p_stop_hold;
        @(posedge aclk) disable iff (!aresetn)
        stop_now && $past(stop_now) |-> $stable(port_a_drv) && $stable(port_c_oe);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("Pins changed in stop");

    property p_dir_out;
        @(posedge aclk) disable iff (!aresetn)
        !stop_now && !$past(stop_now) |=> port_c_oe == $past(c_dir_reg);
    endproperty
    a_dir_out: assert property (p_dir_out) else $error("Port c direction mismatch");

    property p_od_high;
        @(posedge aclk) disable iff (!aresetn)
        !stop_now |=> ((port_b_drv.oe & $past(b_reg.od & b_out)) == 8'h00);
    endproperty
    a_od_high: assert property (p_od_high) else $error("Open-drain drove high");

    property p_irq_route;
        @(posedge aclk) disable iff (!aresetn)
        !b_alt_reg[ALT_IRQ1] |=> !ext_irq_in_first;
    endproperty
    a_irq_route: assert property (p_irq_route) else $error("Interrupt routed while disabled");

    property p_reset_in;
        @(posedge aclk) !aresetn |=> port_a_drv.oe == 8'h00 && port_b_drv.oe == 8'h00 && !remote_drive_out;
    endproperty
    a_reset_in: assert property (p_reset_in) else $error("Pin driven after reset");

    property p_dir_a;
        @(posedge aclk) disable iff (!aresetn)
        !stop_now && !$past(stop_now) |=> port_a_drv.oe == $past(a_reg.dir & ~(a_reg.od & a_reg.data));
    endproperty
    a_dir_a: assert property (p_dir_a) else $error("Port a enable mismatch");

    property p_irq2_route;
        @(posedge aclk) disable iff (!aresetn)
        !b_alt_reg[ALT_IRQ2] |=> !ext_irq_in_second;
    endproperty
    a_irq2_route: assert property (p_irq2_route) else $error("Second interrupt routed while disabled");

    property p_ec_route;
        @(posedge aclk) disable iff (!aresetn)
        !b_alt_reg[ALT_EC] |=> !event_count_in;
    endproperty
    a_ec_route: assert property (p_ec_route) else $error("Counter input routed while disabled");

    property p_timer_mux;
        @(posedge aclk) disable iff (!aresetn)
        b_alt_reg[ALT_T0] && !b_reg.od[7] && !stop_now |=> port_b_drv.o[7] == $past(timer_out_zero);
    endproperty
    a_timer_mux: assert property (p_timer_mux) else $error("Timer output not on port b bit 7");

    property p_ks_quiet;
        @(posedge aclk) disable iff (!aresetn)
        (a_reg.ks == 8'h00) && (b_reg.ks == 8'h00) |=> !key_scan_hit;
    endproperty
    a_ks_quiet: assert property (p_ks_quiet) else $error("Key scan hit with no scan pin");

    property p_remote_on;
        @(posedge aclk) disable iff (!aresetn)
        ctrl_reg[CTRL_REM] && !stop_now |=> remote_drive_out;
    endproperty
    a_remote_on: assert property (p_remote_on) else $error("Remote output not driven");
endmodule // gpio_ports

// >>> bench/pin_model.sv
`timescale 1ns/100ps
module pin_model import gpio_pkg::*; #(
    parameter int unsigned C_BITS = 5
) (
    input  wire logic              aclk,
    input  wire pin_drive_t        a_drv,
    input  wire pin_drive_t        b_drv,
    input  wire logic [C_BITS-1:0] c_o,
    input  wire logic [C_BITS-1:0] c_oe,
    input  wire logic [C_BITS-1:0] c_pu,
    input  wire logic [7:0]        en_a,
    input  wire logic [7:0]        val_a,
    input  wire logic [7:0]        en_b,
    input  wire logic [7:0]        val_b,
    output logic [7:0]             a_in,
    output logic [7:0]             b_in,
    output logic [C_BITS-1:0]      c_in
);
    // Undriven pins wander each cycle so a stale level never reads as valid
    logic fl_reg = 1'b0;

    always_ff @(posedge aclk) fl_reg <= ~fl_reg;

    function automatic logic lvl(input logic oe, o, en, v, pu, f);
        if (oe) return o;
        if (en) return v; // External keypad or source drives the pin
        if (pu) return 1'b1;
        return f;
    endfunction

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            a_in[i] = lvl(a_drv.oe[i], a_drv.o[i], en_a[i], val_a[i], a_drv.pu[i], fl_reg ^ i[0]);
            b_in[i] = lvl(b_drv.oe[i], b_drv.o[i], en_b[i], val_b[i], b_drv.pu[i], fl_reg ^ i[0]);
        end
        for (int i = 0; i < C_BITS; i++) begin
            c_in[i] = lvl(c_oe[i], c_o[i], 1'b0, 1'b0, c_pu[i], fl_reg ^ i[0]);
        end
    end
endmodule // pin_model

// >>> bench/remote_ctrl_mcu_io_ports_tb.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin failures++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module remote_ctrl_mcu_io_ports_tb import gpio_pkg::*;;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, t0, t1, t2, irq1, irq2, ec, ks_hit, stop, rem;
    logic [AW-1:0] awaddr, araddr;
    logic [31:0]   wdata, rdata, rd_q;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp, resp_q;
    logic [7:0]    a_in, b_in, en_a, val_a, en_b, val_b;
    logic [4:0]    c_in, c_o, c_oe, c_pu;
    pin_drive_t    a_drv, b_drv;
    int            failures, n_tests;

    gpio_ports #(.C_BITS(5)) gpio_ports_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port_a_in(a_in), .port_a_drv(a_drv), .port_b_in(b_in), .port_b_drv(b_drv), .port_c_in(c_in),
        .port_c_o(c_o), .port_c_oe(c_oe), .port_c_pu(c_pu), .timer_out_zero(t0), .timer_out_one(t1),
        .timer_out_two(t2), .ext_irq_in_first(irq1), .ext_irq_in_second(irq2), .event_count_in(ec),
        .key_scan_hit(ks_hit), .stop_mode(stop), .remote_drive_out(rem));

    pin_model #(.C_BITS(5)) pin_model_inst (.aclk(aclk), .a_drv(a_drv), .b_drv(b_drv), .c_o(c_o),
        .c_oe(c_oe), .c_pu(c_pu), .en_a(en_a), .val_a(val_a), .en_b(en_b), .val_b(val_b),
        .a_in(a_in), .b_in(b_in), .c_in(c_in));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic end_sim;
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic settle;
        repeat (3) @(posedge aclk);
        #1;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
        bit aw_p, w_p;
        @(posedge aclk);
        awaddr <= a;
        wdata <= 32'(d);
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_p = 1;
        w_p = 1;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (aw_p && awready) begin
                awvalid <= 1'b0;
                aw_p = 0;
            end
            if (w_p && wready) begin
                wvalid <= 1'b0;
                w_p = 0;
            end
        end
        while (!bvalid) @(posedge aclk);
        resp_q = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [AW-1:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        rd_q = rdata;
        resp_q = rresp;
        rready <= 1'b0;
    endtask

    initial begin
        #200000;
        failures++;
        end_sim;
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, t0, t1, t2} = '0;
        {awaddr, araddr, wdata, wstrb, en_a, val_a, en_b, val_b} = '0;
        aresetn = 1'b0; // Reset pin pulled low by the outside party
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        settle;
        `CHK("a_oe", 8'h00, a_drv.oe)
        `CHK("c_oe", 5'h00, c_oe)
        `CHK("remote", 1'b0, rem)
        wr(ADDR_A_DIR, 8'h5A);
        wr(ADDR_A_PULL, 8'hFF);
        wr(ADDR_A_DATA, 8'h0F);
        en_a <= 8'hA5;
        val_a <= 8'h81;
        settle;
        `CHK("a_oe", 8'h5A, a_drv.oe)
        `CHK("a_pu", 8'hA5, a_drv.pu)
        `CHK("a_o", 8'h0A, a_drv.o & a_drv.oe)
        rd(ADDR_PIN_IN);
        `CHK("a_pins", 8'h8B, rd_q[7:0])
        wr(ADDR_A_KS, 8'h01);
        settle;
        `CHK("ks_idle", 1'b0, ks_hit)
        val_a <= 8'h80;
        settle;
        `CHK("ks_hit", 1'b1, ks_hit)
        wr(ADDR_A_OD, 8'hFF);
        wr(ADDR_A_DATA, 8'hF0);
        settle;
        `CHK("a_od_oe", 8'h0A, a_drv.oe)
        t0 <= 1'b1;
        t2 <= 1'b1;
        wr(ADDR_B_DIR, 8'hE0);
        wr(ADDR_B_ALT, 8'hF6);
        en_b <= 8'h16;
        val_b <= 8'h16;
        settle;
        `CHK("b_irq", 3'b111, {irq1, irq2, ec})
        `CHK("b_tmr", 3'b101, b_drv.o[7:5])
        wr(ADDR_B_ALT, 8'h00);
        settle;
        `CHK("b_irq_off", 3'b000, {irq1, irq2, ec})
        wr(ADDR_B_PULL, 8'hFF);
        wr(ADDR_B_DATA, 8'hC0);
        wr(ADDR_B_OD, 8'h80);
        settle;
        `CHK("b_od_oe", 8'h60, b_drv.oe)
        `CHK("b_pu", 8'h1F, b_drv.pu)
        `CHK("b_o", 8'h40, b_drv.o & b_drv.oe)
        rd(ADDR_PIN_IN);
        `CHK("b_pins", 8'h1F, rd_q[15:8] & 8'h1F)
        wr(ADDR_C_DIR, 8'h15);
        wr(ADDR_C_PULL, 8'h1F);
        wr(ADDR_C_DATA, 8'h1F);
        settle;
        `CHK("c_oe", 5'h15, c_oe)
        `CHK("c_pu", 5'h0A, c_pu)
        `CHK("c_o", 5'h15, c_o & c_oe)
        wr(ADDR_CTRL, 8'h02);
        settle;
        `CHK("remote_on", 1'b1, rem)
        wr(ADDR_CTRL, 8'h03);
        wr(ADDR_A_DIR, 8'h00);
        settle;
        `CHK("stop", 1'b1, stop)
        `CHK("remote_stop", 1'b0, rem)
        `CHK("a_oe_stop", 8'h0A, a_drv.oe)
        wr(ADDR_CTRL, 8'h00);
        settle;
        `CHK("a_oe_wake", 8'h00, a_drv.oe)
        // Refused and strobe-less writes must leave the port a direction register alone
        wr(6'h01, 8'hFF);
        `CHK("resp_unal", RESP_SLVERR, resp_q)
        wr(6'h3C, 8'hFF);
        `CHK("resp_high", RESP_SLVERR, resp_q)
        rd(6'h3E);
        `CHK("rresp_unal", RESP_SLVERR, resp_q)
        wr(ADDR_A_DIR, 8'hFF, 4'h0);
        `CHK("resp_nostrb", RESP_OKAY, resp_q)
        rd(ADDR_A_DIR);
        `CHK("a_dir_kept", 8'h00, rd_q[7:0])
        wr(ADDR_CTRL, 8'h02);
        wr(ADDR_A_DIR, 8'hFF);
        @(posedge aclk);
        aresetn <= 1'b0;
        settle;
        `CHK("a_oe_rst", 8'h00, a_drv.oe)
        `CHK("remote_rst", 1'b0, rem)
        @(posedge aclk);
        aresetn <= 1'b1;
        settle;
        `CHK("a_oe_rel", 8'h00, a_drv.oe)
        end_sim;
    end
endmodule // remote_ctrl_mcu_io_ports_tb
